// File: iss_pkg.sv
// shared constants, register map and types of the i2c slave status block
`default_nettype none
package iss_pkg;
  // register indices; byte address is four times the index
  localparam int ISS_ADR_W = 18;
  localparam logic [15:0] ISS_IDX_TXD = 16'h4360;
  localparam logic [15:0] ISS_IDX_RXD = 16'h4362;
  localparam logic [15:0] ISS_IDX_OWN = 16'h4364;
  localparam logic [15:0] ISS_IDX_CTL = 16'h4366;
  localparam logic [15:0] ISS_IDX_FLG = 16'h4368;
  localparam logic [15:0] ISS_IDX_AST = 16'h436a;
  localparam logic [15:0] ISS_IDX_IEN = 16'h436c;
  localparam logic [15:0] ISS_IDX_MSK = 16'h436e;
  // event flag register fields
  localparam int ISS_FLG_W = 6;
  localparam int ISS_FLG_STOP = 0;
  localparam int ISS_FLG_NAK = 1;
  localparam int ISS_FLG_ASD = 2;
  localparam int ISS_FLG_DMS = 3;
  localparam int ISS_FLG_BFR = 4;
  localparam int ISS_FLG_OVF = 5;
  localparam int ISS_FLG_BUS_STATUS_SUMMARY = 7;
  // access state fields
  localparam int ISS_AST_DIR = 0;
  localparam int ISS_AST_SEL = 1;
  localparam int ISS_AST_BUSY = 2;
  localparam int ISS_AST_TXE = 3;
  localparam int ISS_AST_RXR = 4;
  // interrupt enable fields
  localparam int ISS_IEN_W = 3;
  localparam int ISS_IEN_TX = 0;
  localparam int ISS_IEN_RX = 1;
  localparam int ISS_IEN_BS = 2;
  // control fields
  localparam int ISS_CTL_W = 2;
  localparam int ISS_CTL_COMM = 0;
  localparam int ISS_CTL_ASYNC = 1;
  // reset values
  localparam logic [ISS_FLG_W-1:0] ISS_FLG_RST = 6'h00;
  localparam logic [ISS_IEN_W-1:0] ISS_IEN_RST = 3'h0;
  localparam logic [ISS_CTL_W-1:0] ISS_CTL_RST = 2'h0;
  localparam logic [6:0] ISS_OWN_RST = 7'h00;
  localparam logic [7:0] ISS_BYTE_RST = 8'h00;
  localparam logic [2:0] ISS_BIT_LAST = 3'h7;
  localparam logic [2:0] ISS_BIT_FIRST = 3'h0;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } iss_cond_type;

  typedef enum logic [7:0] {
    ISS_IDLE = 8'h01,
    ISS_ADDR = 8'h02,
    ISS_ADDR_ACK = 8'h04,
    ISS_ADDR_NAK = 8'h08,
    ISS_RX = 8'h10,
    ISS_RX_ACK = 8'h20,
    ISS_TX = 8'h40,
    ISS_TX_ACK = 8'h80
  } iss_state_type;
endpackage
`default_nettype wire

// File: iss_sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module iss_sync2 #(
  parameter int W = 2
) (
  input wire logic clk_i, // block clock
  input wire logic rst_i, // sync reset, high
  input wire logic [W-1:0] d_i, // asynchronous levels
  output logic [W-1:0] q_o // synchronised levels
);
  logic [W-1:0] meta_q;

  // bus idles high, so both stages reset to one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '1;
      q_o <= '1;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // iss_sync2
`default_nettype wire

// File: iss_cond.sv
// start, stop and clock edge detection on synchronised bus lines
`timescale 1ns/1ps
`default_nettype none
module iss_cond
  import iss_pkg::*;
(
  input wire logic clk_i, // block clock
  input wire logic rst_i, // sync reset, high
  input wire logic scl_i, // synchronised clock line
  input wire logic sda_i, // synchronised data line
  output iss_cond_type cond_o // one-cycle bus events
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_comb
  begin
    cond_o.rise = scl_i & ~scl_q;
    cond_o.fall = ~scl_i & scl_q;
    cond_o.start = scl_i & scl_q & sda_q & ~sda_i;
    cond_o.stop = scl_i & scl_q & ~sda_q & sda_i;
  end
endmodule // iss_cond
`default_nettype wire

// File: iss_slave_status.sv
// i2c slave status, access state and interrupt request logic
// Contract
// - while sending, compare sda with driven bit; set mismatch flag on difference
// - never raise the mismatch flag while async address detection is on
// - async mode: own address sets async-hit flag and is answered with nak
// - after a sent byte, master's nak is captured into the nak flag
// - stop or repeated start while selected sets stop flag, resets engine
// - event flags stay set until software writes one to them
// - receive ready sets on receive load, clears on receive register read
// - transmit empty sets when byte is taken, clears on transmit write
// - busy sets on start or low line, clears on stop
// - selected sets on own address, clears on stop or repeated start
// - direction bit of the address is kept; one means master read
// - bus status request when a flag passing the mask is set and its enable is one
// - receive request on byte load, only with receive enable
// - transmit request on byte handover, only with transmit enable
// - summary flag is one while any event flag is one
`timescale 1ns/1ps
`default_nettype none
module iss_slave_status
  import iss_pkg::*;
(
  input wire logic clk_i, // 25 mhz block clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [ISS_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // cycle answer
  input wire logic scl_i, // slave clock pin
  input wire logic sda_i, // slave data pin level
  output logic sda_o, // data pin drive level
  output logic sda_oe_o, // data pin pulled low while high
  output logic irq_o // level interrupt request
);
  logic [1:0] pin_s;
  iss_cond_type cond;
  iss_state_type state_q;
  logic [2:0] cnt_q;
  logic [8:0] tx_sh_q;
  logic [7:0] rx_sh_q, rxd_q, txd_q;
  logic [6:0] own_q;
  logic [ISS_CTL_W-1:0] ctl_q;
  logic [ISS_IEN_W-1:0] ien_q;
  logic [ISS_FLG_W-1:0] msk_q, flg_q, flg_set, flg_clr;
  logic rxr_q, txe_q, busy_q, sel_q, dir_q, oe_q;
  logic summary, scl_s, sda_s, async_en, addr_hit, rx_load, tx_take;
  logic req, wr, rd;
  logic [15:0] rdata;

  iss_sync2 #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({scl_i, sda_i}),
    .q_o(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  iss_cond u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .cond_o(cond)
  );

  function automatic logic reg_hit(input logic [ISS_ADR_W-1:0] adr, input logic [15:0] idx);
    reg_hit = (adr[ISS_ADR_W-1:2] == idx);
  endfunction

  assign async_en = ctl_q[ISS_CTL_ASYNC];
  assign addr_hit = (rx_sh_q[6:0] == own_q);
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;

  // byte engine; events from sampled pins drive every transition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ISS_IDLE;
      cnt_q <= ISS_BIT_FIRST;
      rx_sh_q <= ISS_BYTE_RST;
      tx_sh_q <= '0;
      oe_q <= 1'b0;
    end
    else if (cond.stop || cond.start)
    begin
      // restart of the engine on either condition
      state_q <= cond.start ? ISS_ADDR : ISS_IDLE;
      cnt_q <= ISS_BIT_FIRST;
      oe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ISS_IDLE:
          oe_q <= 1'b0;
        ISS_ADDR:
          if (cond.rise)
          begin
            rx_sh_q <= {rx_sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == ISS_BIT_LAST)
            begin
              if (rx_sh_q[6:0] == own_q && ctl_q[ISS_CTL_COMM] && !async_en)
                state_q <= ISS_ADDR_ACK;
              else
                state_q <= ISS_ADDR_NAK;
            end
          end
        ISS_ADDR_ACK:
          if (cond.fall)
          begin
            if (!oe_q)
              oe_q <= 1'b1;
            else if (dir_q)
            begin
              state_q <= ISS_TX;
              tx_sh_q <= {txd_q, 1'b0};
              oe_q <= ~txd_q[7];
              cnt_q <= ISS_BIT_FIRST;
            end
            else
            begin
              state_q <= ISS_RX;
              oe_q <= 1'b0;
              cnt_q <= ISS_BIT_FIRST;
            end
          end
        ISS_ADDR_NAK:
          if (cond.rise)
            state_q <= ISS_IDLE;
        ISS_RX:
          if (cond.rise)
          begin
            rx_sh_q <= {rx_sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == ISS_BIT_LAST)
              state_q <= ISS_RX_ACK;
          end
        ISS_RX_ACK:
          if (cond.fall)
          begin
            oe_q <= ~oe_q;
            if (oe_q)
              state_q <= ISS_RX;
          end
        ISS_TX:
          if (cond.rise)
          begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == ISS_BIT_LAST)
              state_q <= ISS_TX_ACK;
          end
          else if (cond.fall)
          begin
            tx_sh_q <= {tx_sh_q[7:0], 1'b0};
            oe_q <= ~tx_sh_q[7];
          end
        ISS_TX_ACK:
          if (cond.fall)
            oe_q <= 1'b0;
          else if (cond.rise)
          begin
            cnt_q <= ISS_BIT_FIRST;
            if (sda_s)
              state_q <= ISS_IDLE;
            else
            begin
              state_q <= ISS_TX;
              tx_sh_q <= {1'b0, txd_q}; // one place low: first fall shifts msb out
            end
          end
      endcase
    end
  end

  // byte hand-over strobes between engine and data registers
  assign rx_load = (state_q == ISS_RX) && cond.rise && (cnt_q == ISS_BIT_LAST)
                   && !cond.start && !cond.stop;
  assign tx_take = !cond.start && !cond.stop &&
                   (((state_q == ISS_ADDR_ACK) && cond.fall && oe_q && dir_q) ||
                    ((state_q == ISS_TX_ACK) && cond.rise && !sda_s));

  always_comb
  begin
    flg_set = '0;
    flg_set[ISS_FLG_DMS] = !async_en && cond.rise && !cond.start && !cond.stop &&
                           (((state_q == ISS_TX) && (sda_s != tx_sh_q[8])) ||
                            ((state_q == ISS_ADDR_NAK) && !sda_s));
    flg_set[ISS_FLG_ASD] = async_en && (state_q == ISS_ADDR) && cond.rise &&
                           (cnt_q == ISS_BIT_LAST) && addr_hit;
    flg_set[ISS_FLG_NAK] = (state_q == ISS_TX_ACK) && cond.rise && sda_s &&
                           !cond.start && !cond.stop;
    flg_set[ISS_FLG_STOP] = sel_q && (cond.stop || cond.start);
    flg_set[ISS_FLG_OVF] = rx_load && rxr_q;
  end

  // write one to clear; a set in the same cycle wins
  assign flg_clr = (wr && reg_hit(wb_adr_i, ISS_IDX_FLG) && wb_sel_i[0]) ?
                   wb_dat_i[ISS_FLG_W-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flg_q <= ISS_FLG_RST;
    else
      flg_q <= (flg_q & ~flg_clr) | flg_set;
  end

  assign summary = |flg_q;

  // receive data and ready indicator
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxd_q <= ISS_BYTE_RST;
      rxr_q <= 1'b0;
    end
    else
    begin
      if (rx_load)
        rxd_q <= {rx_sh_q[6:0], sda_s};
      if (rx_load)
        rxr_q <= 1'b1;
      else if (rd && reg_hit(wb_adr_i, ISS_IDX_RXD))
        rxr_q <= 1'b0;
    end
  end

  // transmit data and empty indicator; a write in the hand-over cycle
  // stays pending, so the empty flag is cleared by the write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txd_q <= ISS_BYTE_RST;
      txe_q <= 1'b0;
    end
    else
    begin
      if (wr && reg_hit(wb_adr_i, ISS_IDX_TXD) && wb_sel_i[0])
      begin
        txd_q <= wb_dat_i[7:0];
        txe_q <= 1'b0;
      end
      else if (tx_take)
        txe_q <= 1'b1;
    end
  end

  // bus busy and slave selection state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      sel_q <= 1'b0;
      dir_q <= 1'b0;
    end
    else
    begin
      if (cond.stop)
        busy_q <= 1'b0;
      else if (cond.start || !scl_s || !sda_s)
        busy_q <= 1'b1;
      if (cond.stop || cond.start)
        sel_q <= 1'b0;
      else if ((state_q == ISS_ADDR) && cond.rise && (cnt_q == ISS_BIT_LAST) &&
               addr_hit && ctl_q[ISS_CTL_COMM] && !async_en)
      begin
        sel_q <= 1'b1;
        dir_q <= sda_s;
      end
    end
  end

  // software control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      own_q <= ISS_OWN_RST;
      ctl_q <= ISS_CTL_RST;
      ien_q <= ISS_IEN_RST;
      msk_q <= ISS_FLG_RST;
    end
    else if (wr && wb_sel_i[0])
    begin
      if (reg_hit(wb_adr_i, ISS_IDX_OWN))
        own_q <= wb_dat_i[6:0];
      if (reg_hit(wb_adr_i, ISS_IDX_CTL))
        ctl_q <= wb_dat_i[ISS_CTL_W-1:0];
      if (reg_hit(wb_adr_i, ISS_IDX_IEN))
        ien_q <= wb_dat_i[ISS_IEN_W-1:0];
      if (reg_hit(wb_adr_i, ISS_IDX_MSK))
        msk_q <= wb_dat_i[ISS_FLG_W-1:0];
    end
  end

  // read multiplexer; unmapped and reserved bits read zero
  always_comb
  begin
    rdata = 16'h0000;
    if (reg_hit(wb_adr_i, ISS_IDX_RXD))
      rdata[7:0] = rxd_q;
    if (reg_hit(wb_adr_i, ISS_IDX_TXD))
      rdata[7:0] = txd_q;
    if (reg_hit(wb_adr_i, ISS_IDX_OWN))
      rdata[6:0] = own_q;
    if (reg_hit(wb_adr_i, ISS_IDX_CTL))
      rdata[ISS_CTL_W-1:0] = ctl_q;
    if (reg_hit(wb_adr_i, ISS_IDX_FLG))
      rdata[ISS_FLG_BUS_STATUS_SUMMARY:0] = {summary, 1'b0, flg_q};
    if (reg_hit(wb_adr_i, ISS_IDX_AST))
      rdata[ISS_AST_RXR:ISS_AST_DIR] = {rxr_q, txe_q, busy_q, sel_q, dir_q};
    if (reg_hit(wb_adr_i, ISS_IDX_IEN))
      rdata[ISS_IEN_W-1:0] = ien_q;
    if (reg_hit(wb_adr_i, ISS_IDX_MSK))
      rdata[ISS_FLG_W-1:0] = msk_q;
  end

  // bus slave answers one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= {16'h0000, rdata};
    end
  end

  // mask trims which events reach the bus status request; the summary
  // bit itself still shows every event
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= (ien_q[ISS_IEN_BS] && summary && |(flg_q & msk_q)) ||
               (ien_q[ISS_IEN_RX] && rxr_q) ||
               (ien_q[ISS_IEN_TX] && txe_q);
  end

  assign sda_oe_o = oe_q;
  assign sda_o = 1'b0;
endmodule // iss_slave_status
`default_nettype wire

// File: iss_slave_status_props.sv
// concurrent checks on the ports of the slave status block
`timescale 1ns/1ps
`default_nettype none
module iss_slave_status_props
  import iss_pkg::*;
(
  input wire logic clk_i, // block clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [ISS_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // answer
  input wire logic scl_i, // clock pin
  input wire logic sda_i, // data pin
  input wire logic sda_o, // data drive level
  input wire logic sda_oe_o, // data pull enable
  input wire logic irq_o // interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] ien_q;
  logic rd_flg;
  logic rd_ast;
  logic rd_ien;
  assign rd_flg = wb_ack_o && !wb_we_i && (wb_adr_i[17:2] == ISS_IDX_FLG);
  assign rd_ast = wb_ack_o && !wb_we_i && (wb_adr_i[17:2] == ISS_IDX_AST);
  assign rd_ien = wb_ack_o && !wb_we_i && (wb_adr_i[17:2] == ISS_IDX_IEN);
  // shadow of the enables, taken at the edge the master sees ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ien_q <= 3'h0;
    else if (wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i[17:2] == ISS_IDX_IEN)
      ien_q <= wb_dat_i[2:0];
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  flg_rsvd_a: assert property (rd_flg |-> wb_dat_o[15:8] == 8'h00 && !wb_dat_o[6])
    else $error("reserved flag bits not zero");
  ast_rsvd_a: assert property (rd_ast |-> wb_dat_o[31:5] == 27'h0)
    else $error("reserved access state bits not zero");
  ien_rsvd_a: assert property (rd_ien |-> wb_dat_o[31:3] == 29'h0)
    else $error("reserved enable bits not zero");
  summary_a: assert property (rd_flg |-> wb_dat_o[7] == (|wb_dat_o[5:0]))
    else $error("summary flag disagrees with event flags");
  irq_off_a: assert property (ien_q == 3'h0 && $past(ien_q) == 3'h0 |-> !irq_o)
    else $error("interrupt with all enables off");
endmodule // iss_slave_status_props

bind iss_slave_status iss_slave_status_props i_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o)
);
`default_nettype wire

// File: iss_bus_master.sv
// behavioural i2c bus master driving the slave's pins
`timescale 1ns/1ps
`default_nettype none
module iss_bus_master (
  input wire logic clk_i, // bench clock
  input wire logic sda_i, // resolved data line
  output logic scl_o, // clock line, idle high
  output logic sda_low_o // pulls the data line low
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // data moves a clock after scl falls so the slave never sees a false stop
  task automatic bit_x(input logic b, output logic r);
    w(1);
    sda_low_o <= !b;
    w(3);
    scl_o <= 1'b1;
    w(2);
    r = sda_i;
    w(2);
    scl_o <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q = {q[6:0], r};
    end
  endtask
  task automatic start_c;
    w(1);
    sda_low_o <= 1'b0;
    w(3);
    scl_o <= 1'b1;
    w(2);
    sda_low_o <= 1'b1;
    w(2);
    scl_o <= 1'b0;
  endtask
  task automatic stop_c;
    w(1);
    sda_low_o <= 1'b1;
    w(3);
    scl_o <= 1'b1;
    w(2);
    sda_low_o <= 1'b0;
    w(4);
  endtask
endmodule // iss_bus_master
`default_nettype wire

// File: tb_iss_slave_status.sv
// self-checking bench for the slave status block
`timescale 1ns/1ps
`default_nettype none
module tb_iss_slave_status
  import iss_pkg::*;
;
  localparam logic [31:0] ALL_M = 32'hffffffff;
  logic clk_i, rst_i, cyc, stb, we, ack, sda_oe, sda_o, irq, scl, sda_low, sda, r;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, rd_v;
  logic [7:0] q;
  int n_mismatch, comparisons, cycles;
  // open-drain data line with pull-up
  assign sda = ~(sda_low | sda_oe);
  iss_slave_status i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq)
  );
  iss_bus_master i_mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd_v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, rd_v & m);
  endtask
  task automatic bx(input logic b);
    i_mst.bit_x(b, r);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic addr(input logic [7:0] a, input logic nak);
    i_mst.start_c();
    i_mst.byte_x(a, q);
    bx(1'b1);
    chk("ack slot", {31'h0, nak}, {31'h0, r});
  endtask
  initial
  begin
    {rst_i, cyc, stb, we, adr, sel, dat} = {1'b1, 3'h0, 18'h0, 4'hf, 32'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("flags", ISS_IDX_FLG, ALL_M, 32'h0);
    rd("state", ISS_IDX_AST, ALL_M, 32'h0);
    bus(1'b1, ISS_IDX_IEN, 32'hffff);
    rd("enables", ISS_IDX_IEN, ALL_M, 32'h7);
    rd("unmapped", 16'h4000, ALL_M, 32'h0);
    bus(1'b1, ISS_IDX_OWN, 32'h2a);
    bus(1'b1, ISS_IDX_CTL, 32'h1);
    bus(1'b1, ISS_IDX_IEN, 32'h2);
    bus(1'b1, ISS_IDX_MSK, 32'hff);
    $display("test regs done");
    addr(8'h54, 1'b0);
    rd("state", ISS_IDX_AST, ALL_M, 32'h6);
    chk("sda level", 32'h0, {31'h0, sda_o});
    i_mst.byte_x(8'ha5, q);
    bx(1'b0);
    rd("state", ISS_IDX_AST, 32'h10, 32'h10);
    chk("rx irq", 32'h1, {31'h0, irq});
    rd("rx data", ISS_IDX_RXD, 32'hff, 32'ha5);
    rd("state", ISS_IDX_AST, 32'h10, 32'h0);
    chk("rx irq", 32'h0, {31'h0, irq});
    i_mst.stop_c();
    rd("flags", ISS_IDX_FLG, ALL_M, 32'h81);
    rd("state", ISS_IDX_AST, ALL_M, 32'h0);
    bus(1'b1, ISS_IDX_FLG, 32'h0);
    rd("flags", ISS_IDX_FLG, ALL_M, 32'h81);
    bus(1'b1, ISS_IDX_FLG, 32'h1);
    rd("flags", ISS_IDX_FLG, ALL_M, 32'h0);
    $display("test write done");
    bus(1'b1, ISS_IDX_TXD, 32'h3c);
    bus(1'b1, ISS_IDX_IEN, 32'h1);
    addr(8'h55, 1'b0);
    rd("state", ISS_IDX_AST, ALL_M, 32'hf);
    chk("tx irq", 32'h1, {31'h0, irq});
    bus(1'b1, ISS_IDX_TXD, 32'hc3);
    rd("state", ISS_IDX_AST, 32'h8, 32'h0);
    i_mst.byte_x(8'hff, q);
    chk("byte one", 32'h3c, {24'h0, q});
    bx(1'b0);
    rd("state", ISS_IDX_AST, 32'h8, 32'h8);
    i_mst.byte_x(8'hff, q);
    chk("byte two", 32'hc3, {24'h0, q});
    bx(1'b1);
    rd("flags", ISS_IDX_FLG, ALL_M, 32'h82);
    bus(1'b1, ISS_IDX_IEN, 32'h4);
    chk("status irq", 32'h1, {31'h0, irq});
    i_mst.stop_c();
    bus(1'b1, ISS_IDX_FLG, 32'hff);
    rd("flags", ISS_IDX_FLG, ALL_M, 32'h0);
    chk("status irq", 32'h0, {31'h0, irq});
    $display("test read done");
    // the master fights the slave's ones by holding the line low
    bus(1'b1, ISS_IDX_TXD, 32'hff);
    addr(8'h55, 1'b0);
    i_mst.byte_x(8'h00, q);
    rd("flags", ISS_IDX_FLG, 32'h8, 32'h8);
    bx(1'b1);
    i_mst.stop_c();
    bus(1'b1, ISS_IDX_FLG, 32'hff);
    // another slave acks its own address; not selected, but the mismatch flag sets
    i_mst.start_c();
    i_mst.byte_x(8'h56, q);
    bx(1'b0);
    rd("flags", ISS_IDX_FLG, 32'h8, 32'h8);
    rd("state", ISS_IDX_AST, 32'h2, 32'h0);
    i_mst.stop_c();
    bus(1'b1, ISS_IDX_FLG, 32'hff);
    $display("test mismatch done");
    bus(1'b1, ISS_IDX_CTL, 32'h3);
    i_mst.start_c();
    i_mst.byte_x(8'h54, q);
    // another slave acks while this one must answer nak
    bx(1'b0);
    rd("flags", ISS_IDX_FLG, 32'hc, 32'h4);
    i_mst.stop_c();
    bus(1'b1, ISS_IDX_CTL, 32'h1);
    addr(8'h54, 1'b0);
    i_mst.stop_c();
    bus(1'b1, ISS_IDX_FLG, 32'hff);
    rd("flags", ISS_IDX_FLG, 32'hc, 32'h0);
    $display("test async done");
    end_sim();
  end
endmodule // tb_iss_slave_status
`default_nettype wire
